/* rtl/cmpc_pkg.sv */
// constants and types shared by the mode and protection control registers
package cmpc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] CMPC_ADDR_MODE     = 8'h18;
  localparam logic [7:0] CMPC_ADDR_PROT     = 8'h19;
  localparam logic [7:0] CMPC_RST_MODE      = 8'h04;
  localparam logic [7:0] CMPC_RST_PROT      = 8'hC0;
  // reset value of the protection register on the variant without negotiation
  localparam logic [7:0] CMPC_RST_PROT_EXT  = 8'hC4;

  // ************************************************************
  // field positions, mode and power switch register
  // ************************************************************
  localparam int MODE_BOOST_EN_BIT    = 6;
  localparam int MODE_BOOST_SKIP_BIT  = 5;
  localparam int MODE_FWD_SKIP_BIT    = 4;
  localparam int MODE_WITH_INPUT_BIT  = 3;
  localparam int MODE_DLY_SEL_BIT     = 2;
  localparam int MODE_ACTION_LSB      = 0;

  // ************************************************************
  // field positions, protection and adapter register
  // ************************************************************
  localparam int PROT_PEAK_LSB        = 6;
  localparam int PROT_UV_SEL_BIT      = 5;
  localparam int PROT_BOOST_MIN_BIT   = 4;
  localparam int PROT_REQ9_BIT        = 3;
  localparam int PROT_REQ12_BIT       = 2;
  localparam int PROT_RATE_LSB        = 0;

  // ************************************************************
  // serial bus
  // ************************************************************
  // arbitrary neutral bus address
  localparam logic [6:0] CMPC_DEV_ADDR    = 7'h2A;
  localparam logic [3:0] CMPC_BITS_BYTE   = 4'h8;
  localparam logic [3:0] CMPC_LAST_TX_BIT = 4'h7;

  // ************************************************************
  // timing
  // ************************************************************
  localparam real         CMPC_CLK_HZ        = 100.0e6;
  localparam real         SW_DLY_SHORT_MS    = 25.0;
  localparam real         SW_DLY_LONG_S      = 12.5;
  localparam int unsigned SW_DLY_SHORT_CYC   =
    $rtoi(SW_DLY_SHORT_MS * CMPC_CLK_HZ / 1000.0);
  localparam int unsigned SW_DLY_LONG_CYC    =
    $rtoi(SW_DLY_LONG_S * CMPC_CLK_HZ);
  localparam int          SW_CNT_W           = 31;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    ACT_NORMAL   = 2'b00,
    ACT_SHUTDOWN = 2'b01,
    ACT_SHIP     = 2'b10,
    ACT_SYS_RST  = 2'b11
  } cmpc_action_t;

  typedef enum logic [2:0] {
    NEG_DCP   = 3'b000,
    NEG_TRY12 = 3'b001,
    NEG_TRY9  = 3'b010,
    NEG_AT12  = 3'b011,
    NEG_AT9   = 3'b100
  } cmpc_neg_t;

  typedef enum logic [3:0] {
    BUS_IDLE     = 4'h0,
    BUS_ADDR     = 4'h1,
    BUS_ADDR_ACK = 4'h2,
    BUS_PTR      = 4'h3,
    BUS_PTR_ACK  = 4'h4,
    BUS_WR       = 4'h5,
    BUS_WR_ACK   = 4'h6,
    BUS_RD       = 4'h7,
    BUS_RD_ACK   = 4'h8
  } cmpc_bus_t;

endpackage

/* rtl/cmpc_regs.sv */
// mode, power switch and protection control registers behind the serial bus
`timescale 1ns/1ps
module cmpc_regs #(
  parameter bit          NEG_VARIANT   = 1'b1,
  parameter int unsigned SHORT_DLY_CYC = cmpc_pkg::SW_DLY_SHORT_CYC,
  parameter int unsigned LONG_DLY_CYC  = cmpc_pkg::SW_DLY_LONG_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       input_uv_i,
  input  wire logic       wdog_expired_i,
  input  wire logic       reg_reset_req_i,
  output logic            reg_reset_done_o,
  input  wire logic       neg_done_i,
  input  wire logic       neg_pass_i,
  output logic            dpdm_bias_o,
  output logic            neg_busy_o,
  output logic            neg_try_twelve_o,
  output logic            boost_output_enable_o,
  output logic            boost_light_load_skip_disable_o,
  output logic            forward_light_load_skip_disable_o,
  output logic [1:0]      battery_switch_action_o,
  output logic            battery_switch_fire_o,
  output logic [1:0]      discharge_peak_current_limit_o,
  output logic            battery_undervoltage_select_o,
  output logic            boost_min_battery_voltage_o,
  output logic            external_current_limit_enable_o,
  output logic [1:0]      fast_charge_rate_select_o
);
  import cmpc_pkg::*;

  // ************************************************************
  // reset values per variant
  // ************************************************************
  localparam logic [7:0] PROT_RST =
    NEG_VARIANT ? CMPC_RST_PROT : CMPC_RST_PROT_EXT;
  // bit 3 is reserved on the variant without negotiation
  localparam logic [7:0] PROT_WMASK = NEG_VARIANT ? 8'hFF : 8'hF7;

  // ************************************************************
  // state
  // ************************************************************
  logic                scl_s1_q;
  logic                scl_s2_q;
  logic                scl_s3_q;
  logic                sda_s1_q;
  logic                sda_s2_q;
  logic                sda_s3_q;
  logic                uv_s1_q;
  logic                uv_s2_q;
  cmpc_bus_t           bus_q;
  logic [3:0]          cnt_q;
  logic [7:0]          shift_q;
  logic [7:0]          ptr_q;
  logic [7:0]          tx_q;
  logic                rw_q;
  logic                nack_q;
  logic [6:0]          mode_q;
  logic [7:0]          prot_q;
  logic                done_q;
  cmpc_neg_t           neg_q;
  logic                neg_arm_q;
  logic                arm_q;

  // ************************************************************
  // read decode
  // ************************************************************
  function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                         input logic [6:0] m,
                                         input logic [7:0] p);
    logic [7:0] r;
    r = 8'h00;
    if (a == CMPC_ADDR_MODE) begin
      r = {1'b0, m};
    end else if (a == CMPC_ADDR_PROT) begin
      r = p;
    end
    return r;
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      uv_s1_q  <= 1'b0;
      uv_s2_q  <= 1'b0;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      uv_s1_q  <= input_uv_i;
      uv_s2_q  <= uv_s1_q;
    end
  end

  wire logic scl_rise  = scl_s2_q & ~scl_s3_q;
  wire logic scl_fall  = ~scl_s2_q & scl_s3_q;
  wire logic start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  wire logic stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  wire logic byte_in   = scl_fall && (cnt_q == CMPC_BITS_BYTE);
  wire logic addr_hit  = (shift_q[7:1] == CMPC_DEV_ADDR);

  // ************************************************************
  // serial bus slave
  // ************************************************************
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_q   <= BUS_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
      ptr_q   <= 8'h00;
      tx_q    <= 8'h00;
      rw_q    <= 1'b0;
      nack_q  <= 1'b0;
    end else if (start_det) begin
      bus_q <= BUS_ADDR;
      cnt_q <= 4'h0;
    end else if (stop_det) begin
      bus_q <= BUS_IDLE;
    end else begin
      if (scl_rise && (bus_q == BUS_ADDR || bus_q == BUS_PTR ||
                       bus_q == BUS_WR)) begin
        shift_q <= {shift_q[6:0], sda_s2_q};
        cnt_q   <= cnt_q + 4'h1;
      end
      unique case (bus_q)
        BUS_IDLE: begin
        end
        BUS_ADDR: begin
          if (byte_in) begin
            cnt_q <= 4'h0;
            rw_q  <= shift_q[0];
            bus_q <= addr_hit ? BUS_ADDR_ACK : BUS_IDLE;
          end
        end
        BUS_PTR: begin
          if (byte_in) begin
            cnt_q <= 4'h0;
            ptr_q <= shift_q;
            bus_q <= BUS_PTR_ACK;
          end
        end
        BUS_WR: begin
          if (byte_in) begin
            cnt_q <= 4'h0;
            ptr_q <= ptr_q + 8'h01;
            bus_q <= BUS_WR_ACK;
          end
        end
        BUS_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              tx_q  <= rd_byte(ptr_q, mode_q, prot_q);
              bus_q <= BUS_RD;
            end else begin
              bus_q <= BUS_PTR;
            end
          end
        end
        BUS_PTR_ACK, BUS_WR_ACK: begin
          if (scl_fall) begin
            bus_q <= BUS_WR;
          end
        end
        BUS_RD: begin
          if (scl_fall) begin
            if (cnt_q == CMPC_LAST_TX_BIT) begin
              cnt_q <= 4'h0;
              ptr_q <= ptr_q + 8'h01;
              bus_q <= BUS_RD_ACK;
            end else begin
              cnt_q <= cnt_q + 4'h1;
              tx_q  <= {tx_q[6:0], 1'b0};
            end
          end
        end
        BUS_RD_ACK: begin
          if (scl_rise) begin
            nack_q <= sda_s2_q;
          end else if (scl_fall) begin
            if (nack_q) begin
              bus_q <= BUS_IDLE;
            end else begin
              tx_q  <= rd_byte(ptr_q, mode_q, prot_q);
              bus_q <= BUS_RD;
            end
          end
        end
        default: begin
          bus_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = (bus_q == BUS_ADDR_ACK) || (bus_q == BUS_PTR_ACK) ||
                    (bus_q == BUS_WR_ACK) ||
                    ((bus_q == BUS_RD) && !tx_q[7]);

  // ************************************************************
  // register file
  // ************************************************************
  wire logic wr_stb  = (bus_q == BUS_WR) && byte_in && !reg_reset_req_i;
  wire logic wr_mode = wr_stb && (ptr_q == CMPC_ADDR_MODE);
  wire logic wr_prot = wr_stb && (ptr_q == CMPC_ADDR_PROT);

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= CMPC_RST_MODE[6:0];
      prot_q <= PROT_RST;
      done_q <= 1'b0;
      arm_q  <= 1'b0;
    end else begin
      done_q <= reg_reset_req_i;
      // arm a cycle late so the timer sees the freshly written fields
      arm_q  <= wr_mode;
      if (reg_reset_req_i) begin
        mode_q <= CMPC_RST_MODE[6:0];
        prot_q <= PROT_RST;
      end else begin
        if (wr_mode) begin
          mode_q <= shift_q[6:0];
        end
        if (wr_prot) begin
          prot_q <= shift_q & PROT_WMASK;
        end
        if (wdog_expired_i) begin
          prot_q[PROT_REQ12_BIT] <= 1'b0;
        end
      end
    end
  end

  assign reg_reset_done_o = done_q;

  // ************************************************************
  // field outputs
  // ************************************************************
  assign boost_output_enable_o             = mode_q[MODE_BOOST_EN_BIT];
  assign boost_light_load_skip_disable_o   = mode_q[MODE_BOOST_SKIP_BIT];
  assign forward_light_load_skip_disable_o = mode_q[MODE_FWD_SKIP_BIT];
  assign battery_switch_action_o           =
    mode_q[MODE_ACTION_LSB +: 2];
  assign discharge_peak_current_limit_o    = prot_q[PROT_PEAK_LSB +: 2];
  assign battery_undervoltage_select_o     = prot_q[PROT_UV_SEL_BIT];
  assign boost_min_battery_voltage_o       = prot_q[PROT_BOOST_MIN_BIT];
  assign external_current_limit_enable_o   =
    !NEG_VARIANT && prot_q[PROT_REQ12_BIT];
  assign fast_charge_rate_select_o         = prot_q[PROT_RATE_LSB +: 2];

  // ************************************************************
  // battery switch action delay
  // ************************************************************
  cmpc_switch_timer #(
    .SHORT_CYC (SHORT_DLY_CYC),
    .LONG_CYC  (LONG_DLY_CYC)
  ) u_switch_timer (
    .mclk_i       (mclk_i),
    .sys_rst_i    (sys_rst_i),
    .arm_i        (arm_q),
    .action_i     (mode_q[MODE_ACTION_LSB +: 2]),
    .delay_long_i (mode_q[MODE_DLY_SEL_BIT]),
    .with_input_i (mode_q[MODE_WITH_INPUT_BIT]),
    .input_uv_i   (uv_s2_q),
    .fire_o       (battery_switch_fire_o)
  );

  // ************************************************************
  // adapter negotiation sequencer
  // ************************************************************
  wire logic req9  = NEG_VARIANT && prot_q[PROT_REQ9_BIT];
  wire logic req12 = NEG_VARIANT && prot_q[PROT_REQ12_BIT];

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      neg_q     <= NEG_DCP;
      neg_arm_q <= 1'b0;
    end else begin
      unique case (neg_q)
        NEG_DCP: begin
          if (!req9 && !req12) begin
            neg_arm_q <= 1'b1;
          end else if (neg_arm_q) begin
            neg_arm_q <= 1'b0;
            neg_q     <= req12 ? NEG_TRY12 : NEG_TRY9;
          end
        end
        NEG_TRY12: begin
          if (!req9 && !req12) begin
            neg_q <= NEG_DCP;
          end else if (neg_done_i) begin
            if (neg_pass_i) begin
              neg_q <= NEG_AT12;
            end else begin
              neg_q <= req9 ? NEG_TRY9 : NEG_DCP;
            end
          end
        end
        NEG_TRY9: begin
          if (!req9 && !req12) begin
            neg_q <= NEG_DCP;
          end else if (neg_done_i) begin
            neg_q <= neg_pass_i ? NEG_AT9 : NEG_DCP;
          end
        end
        NEG_AT12: begin
          if (!req12) begin
            neg_q <= req9 ? NEG_TRY9 : NEG_DCP;
          end
        end
        NEG_AT9: begin
          if (!req9) begin
            neg_q <= req12 ? NEG_TRY12 : NEG_DCP;
          end
        end
        default: begin
          neg_q <= NEG_DCP;
        end
      endcase
    end
  end

  assign dpdm_bias_o      = (neg_q != NEG_DCP);
  assign neg_busy_o       = (neg_q == NEG_TRY12) || (neg_q == NEG_TRY9);
  assign neg_try_twelve_o = (neg_q == NEG_TRY12);

endmodule

/* rtl/cmpc_switch_timer.sv */
// delay timer that fires the requested battery switch action
`timescale 1ns/1ps
module cmpc_switch_timer #(
  parameter int unsigned SHORT_CYC = cmpc_pkg::SW_DLY_SHORT_CYC,
  parameter int unsigned LONG_CYC  = cmpc_pkg::SW_DLY_LONG_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       arm_i,
  input  wire logic [1:0] action_i,
  input  wire logic       delay_long_i,
  input  wire logic       with_input_i,
  input  wire logic       input_uv_i,
  output logic            fire_o
);
  import cmpc_pkg::*;

  logic [SW_CNT_W-1:0] cnt_q;
  logic                run_q;
  logic                fire_q;

  // ************************************************************
  // decode
  // ************************************************************
  wire logic [SW_CNT_W-1:0] limit =
    delay_long_i ? SW_CNT_W'(LONG_CYC - 1) : SW_CNT_W'(SHORT_CYC - 1);
  wire logic expired  = (cnt_q >= limit);
  wire logic allowed  = with_input_i | input_uv_i;
  wire logic act_idle = (action_i == ACT_NORMAL);

  // ************************************************************
  // counter
  // ************************************************************
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      fire_q <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      if (arm_i) begin
        run_q <= !act_idle;
        cnt_q <= '0;
      end else if (run_q) begin
        if (act_idle) begin
          run_q <= 1'b0;
        end else if (!expired) begin
          cnt_q <= cnt_q + 1'b1;
        end else if (allowed) begin
          fire_q <= 1'b1;
          run_q  <= 1'b0;
        end
      end
    end
  end

  assign fire_o = fire_q;

endmodule

/* testbench/cmpc_host_model.sv */
// host bus master model driving the serial management bus
`timescale 1ns/1ps
module cmpc_host_model #(
  parameter int         QTR_CYC  = 5,
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic qtr();
    repeat (QTR_CYC) @(posedge mclk_i);
  endtask

  // data moves only while the clock line is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_o <= ~b;
    qtr();
    scl_o <= 1'b1;
    qtr();
    r = sda_i;
    qtr();
    scl_o <= 1'b0;
    qtr();
  endtask

  task automatic start_cond();
    sda_low_o <= 1'b0;
    qtr();
    scl_o <= 1'b1;
    qtr();
    sda_low_o <= 1'b1;
    qtr();
    scl_o <= 1'b0;
    qtr();
  endtask

  task automatic stop_cond();
    sda_low_o <= 1'b1;
    qtr();
    scl_o <= 1'b1;
    qtr();
    sda_low_o <= 1'b0;
    qtr();
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic write_reg(input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    logic a0, a1, a2;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, a0);
    put_byte(p, a1);
    put_byte(d, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
    logic a, r;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, a);
    put_byte(p, a);
    start_cond();
    put_byte({DEV_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop_cond();
  endtask
endmodule

/* testbench/cmpc_regs_props.sv */
// port-level assertions for the mode and protection control registers
`timescale 1ns/1ps
module cmpc_regs_chk #(
  parameter int unsigned SHORT_DLY_CYC = 20
) (
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic       wdog_expired_i,
  input wire logic       reg_reset_req_i,
  input wire logic       reg_reset_done_o,
  input wire logic       neg_done_i,
  input wire logic       neg_pass_i,
  input wire logic       dpdm_bias_o,
  input wire logic       neg_busy_o,
  input wire logic       neg_try_twelve_o,
  input wire logic       boost_output_enable_o,
  input wire logic [1:0] battery_switch_action_o,
  input wire logic       battery_switch_fire_o,
  input wire logic [1:0] discharge_peak_current_limit_o,
  input wire logic       battery_undervoltage_select_o,
  input wire logic [1:0] fast_charge_rate_select_o,
  input wire logic       external_current_limit_enable_o
);
  // cycles since the action field last changed
  logic [31:0] since_act_q;
  logic [1:0]  act_last_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      since_act_q <= 32'h0000_0000;
      act_last_q  <= 2'b00;
    end else begin
      act_last_q <= battery_switch_action_o;
      if (battery_switch_action_o != act_last_q) begin
        since_act_q <= 32'h0000_0000;
      end else if (since_act_q != 32'hFFFF_FFFF) begin
        since_act_q <= since_act_q + 32'h0000_0001;
      end
    end
  end

  AST_RESET_DONE: assert property (
    reg_reset_req_i |=> reg_reset_done_o && !boost_output_enable_o
      && battery_switch_action_o == 2'b00)
    else $error("register reset left mode fields set");
  AST_PROT_DEFAULT: assert property (
    reg_reset_req_i |=> discharge_peak_current_limit_o == 2'b11
      && !battery_undervoltage_select_o
      && fast_charge_rate_select_o == 2'b00)
    else $error("register reset left protection fields set");
  AST_FIRE_ONE_CYCLE: assert property (
    battery_switch_fire_o |=> !battery_switch_fire_o)
    else $error("switch action pulse longer than one cycle");
  AST_FIRE_NEEDS_ACTION: assert property (
    battery_switch_fire_o |-> battery_switch_action_o != 2'b00)
    else $error("switch action fired in normal mode");
  AST_FIRE_AFTER_DELAY: assert property (
    battery_switch_fire_o |-> since_act_q >= SHORT_DLY_CYC)
    else $error("switch action fired before its delay");
  AST_WDOG_CLEARS: assert property (
    wdog_expired_i |=> !external_current_limit_enable_o)
    else $error("watchdog did not clear external limit");
  AST_TRY12_BIAS: assert property (
    neg_try_twelve_o |-> neg_busy_o && dpdm_bias_o)
    else $error("twelve volt attempt without bias");
  AST_PASS_SETTLES: assert property (
    neg_busy_o && neg_done_i && neg_pass_i |=> !neg_busy_o && dpdm_bias_o)
    else $error("passed attempt did not settle at level");

  COV_FIRE: cover property (battery_switch_fire_o);
  COV_PASS12: cover property (neg_try_twelve_o && neg_done_i && neg_pass_i);
  COV_REGRST: cover property (reg_reset_req_i ##1 reg_reset_done_o);
endmodule

bind cmpc_regs cmpc_regs_chk #(.SHORT_DLY_CYC(SHORT_DLY_CYC)) i_chk (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wdog_expired_i(wdog_expired_i),
  .reg_reset_req_i(reg_reset_req_i), .reg_reset_done_o(reg_reset_done_o),
  .neg_done_i(neg_done_i), .neg_pass_i(neg_pass_i),
  .dpdm_bias_o(dpdm_bias_o), .neg_busy_o(neg_busy_o),
  .neg_try_twelve_o(neg_try_twelve_o),
  .boost_output_enable_o(boost_output_enable_o),
  .battery_switch_action_o(battery_switch_action_o),
  .battery_switch_fire_o(battery_switch_fire_o),
  .discharge_peak_current_limit_o(discharge_peak_current_limit_o),
  .battery_undervoltage_select_o(battery_undervoltage_select_o),
  .fast_charge_rate_select_o(fast_charge_rate_select_o),
  .external_current_limit_enable_o(external_current_limit_enable_o)
);

/* testbench/tb_top.sv */
// self-checking bench for the mode and protection control registers
`timescale 1ns/1ps
module tb_top;
  import cmpc_pkg::*;
  localparam int unsigned SHORT_CYC = 20;
  localparam int unsigned LONG_CYC  = 50;
  logic       mclk_i, sys_rst_i, scl, sda_low, sda_oe, sda_dut;
  logic       uv = 1'b0, wdog = 1'b0, rrst = 1'b0;
  logic       ndone = 1'b0, npass = 1'b0;
  logic       boost, bskip, fskip, bias, busy, try12, fire;
  logic       uv_sel, bmin, ext_lim, rdone;
  logic [1:0] action, peak, rate, act_q = 2'b00;
  int         errors = 0, tests_run = 0, cyc = 0, act_cyc = 0;
  int         fires = 0, gap = 0;
  wire        sda_w = ~(sda_low | (sda_oe & ~sda_dut));

  cmpc_host_model i_host (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl),
                          .sda_low_o(sda_low));
  cmpc_regs #(.NEG_VARIANT(1'b1), .SHORT_DLY_CYC(SHORT_CYC),
              .LONG_DLY_CYC(LONG_CYC)) i_dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_dut), .sda_oe_o(sda_oe), .input_uv_i(uv),
    .wdog_expired_i(wdog), .reg_reset_req_i(rrst),
    .reg_reset_done_o(rdone), .neg_done_i(ndone), .neg_pass_i(npass),
    .dpdm_bias_o(bias), .neg_busy_o(busy), .neg_try_twelve_o(try12),
    .boost_output_enable_o(boost),
    .boost_light_load_skip_disable_o(bskip),
    .forward_light_load_skip_disable_o(fskip),
    .battery_switch_action_o(action), .battery_switch_fire_o(fire),
    .discharge_peak_current_limit_o(peak),
    .battery_undervoltage_select_o(uv_sel),
    .boost_min_battery_voltage_o(bmin),
    .external_current_limit_enable_o(ext_lim),
    .fast_charge_rate_select_o(rate));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // counts switch pulses and their distance from the last action change
  always @(posedge mclk_i) begin
    cyc   <= cyc + 1;
    act_q <= action;
    if (action !== act_q) begin
      act_cyc <= cyc;
    end
    if (fire === 1'b1) begin
      fires <= fires + 1;
      gap   <= cyc - act_cyc;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    i_host.write_reg(p, d, ok);
    chk({7'h00, ok}, 8'h01);
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    i_host.read_reg(p, d);
    chk(d, e);
  endtask

  function automatic logic [7:0] neg_st();
    return {5'h00, bias, busy, try12};
  endfunction

  task automatic neg_pulse(input logic pass);
    @(posedge mclk_i);
    ndone <= 1'b1;
    npass <= pass;
    @(posedge mclk_i);
    ndone <= 1'b0;
    npass <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask

  task automatic wait_fire(input int n0, input int lo);
    for (int k = 0; k < 300 && fires == n0; k++) begin
      @(posedge mclk_i);
    end
    chk(8'(fires - n0), 8'h01);
    chk({7'h00, gap >= lo && gap <= lo + 4}, 8'h01);
  endtask

  task automatic t_mode();
    rd_chk(CMPC_ADDR_MODE, 8'h04);
    rd_chk(8'h20, 8'h00);
    wr(CMPC_ADDR_MODE, 8'hF4);
    rd_chk(CMPC_ADDR_MODE, 8'h74);
    chk({5'h00, boost, bskip, fskip}, 8'h07);
    wr(CMPC_ADDR_MODE, 8'h04);
    chk({5'h00, boost, bskip, fskip}, 8'h00);
  endtask

  task automatic t_switch();
    int n;
    n = fires;
    wr(CMPC_ADDR_MODE, 8'h09);
    chk({6'h00, action}, 8'h01);
    wait_fire(n, SHORT_CYC);
    n = fires;
    wr(CMPC_ADDR_MODE, 8'h0E);
    chk({6'h00, action}, 8'h02);
    wait_fire(n, LONG_CYC);
    wr(CMPC_ADDR_MODE, 8'h03);
    chk({6'h00, action}, 8'h03);
    repeat (SHORT_CYC + 30) @(posedge mclk_i);
    chk(8'(fires), 8'h02);
    n = fires;
    uv <= 1'b1;
    // two synchroniser stages, the timer flop and the pulse counter
    repeat (6) @(posedge mclk_i);
    chk(8'(fires - n), 8'h01);
    chk({7'h00, gap > SHORT_CYC + 30}, 8'h01);
    uv <= 1'b0;
  endtask

  task automatic t_prot();
    logic [7:0] v;
    rd_chk(CMPC_ADDR_PROT, 8'hC0);
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], i[0], i[1], 2'b00, ~i[1:0]};
      wr(CMPC_ADDR_PROT, v);
      rd_chk(CMPC_ADDR_PROT, v);
      chk({peak, uv_sel, bmin, 2'b00, rate}, v);
    end
  endtask

  task automatic t_neg();
    wr(CMPC_ADDR_PROT, 8'hC0);
    wr(CMPC_ADDR_PROT, 8'hCC);
    chk(neg_st(), 8'h07);
    neg_pulse(1'b1);
    chk(neg_st(), 8'h04);
    wr(CMPC_ADDR_PROT, 8'hC8);
    chk(neg_st(), 8'h06);
    neg_pulse(1'b1);
    wr(CMPC_ADDR_PROT, 8'hC0);
    chk(neg_st(), 8'h00);
    wr(CMPC_ADDR_PROT, 8'hC8);
    chk(neg_st(), 8'h06);
    neg_pulse(1'b1);
    wr(CMPC_ADDR_PROT, 8'hC4);
    chk(neg_st(), 8'h07);
    neg_pulse(1'b0);
    chk(neg_st(), 8'h00);
    wr(CMPC_ADDR_PROT, 8'hC0);
    wr(CMPC_ADDR_PROT, 8'hCC);
    neg_pulse(1'b0);
    chk(neg_st(), 8'h06);
  endtask

  task automatic t_wdog_rrst();
    wr(CMPC_ADDR_PROT, 8'hC4);
    @(posedge mclk_i);
    wdog <= 1'b1;
    @(posedge mclk_i);
    wdog <= 1'b0;
    rd_chk(CMPC_ADDR_PROT, 8'hC0);
    chk({7'h00, ext_lim}, 8'h00);
    wr(CMPC_ADDR_MODE, 8'h75);
    wr(CMPC_ADDR_PROT, 8'h33);
    @(posedge mclk_i);
    rrst <= 1'b1;
    @(posedge mclk_i);
    rrst <= 1'b0;
    #1;
    chk({7'h00, rdone}, 8'h01);
    rd_chk(CMPC_ADDR_MODE, 8'h04);
    rd_chk(CMPC_ADDR_PROT, 8'hC0);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk_i);
    errors++;
    $display("Error at %0t ns: run did not complete", $time);
    report_and_stop();
  end

  initial begin
    sys_rst_i = 1'b1;
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    t_mode();
    t_switch();
    t_prot();
    t_neg();
    t_wdog_rrst();
    report_and_stop();
  end
endmodule
